// [rtl/bus_master_pkg.sv]
// Summary of operation
// - drive address, size, space code and direction at the start of each cycle
// - size outputs give bytes left: 01 byte, 10 word, 11 three, 00 long
// - size outputs stay valid while address strobe is asserted
// - direction valid under address strobe, changes only on read/write turnaround
// - locked output asserted from first cycle until last locked cycle completes
// - four-bit space code valid under address strobe, fixed encoding
// - address names the (most significant) byte, held under address strobe
// - address strobe asserted one clock after cycle start
// - read data captured on the last falling edge of the cycle
// - write drives all sixteen data lines together with address strobe
// - read cycle asserts data strobe together with address strobe
// - write cycle without fast termination asserts data strobe one clock after address strobe; a fast write never asserts it
// - acknowledge pair: none waits, lower 8-bit, upper or both 16-bit
// - internal acknowledge after programmed delay; earlier external ends cycle
// - fast termination finishes access in two clocks without external acknowledge
// - bus fault ends cycle as error, alone or with acknowledge
// - bus fault with halt means retry, not error
// - bus monitor errors only cycles this device starts
// - autovector ends interrupt-acknowledge cycles only, ignored otherwise
package bus_master_pkg;
    localparam int addr_w = 32;
    localparam int data_w = 16;
    localparam logic [1:0] size_byte = 2'h1;
    localparam logic [1:0] size_word = 2'h2;
    localparam logic [1:0] size_three = 2'h3;
    localparam logic [1:0] size_long = 2'h0;
    localparam logic [3:0] space_user_data = 4'h1;
    localparam logic [3:0] space_user_prog = 4'h2;
    localparam logic [3:0] space_sup_data = 4'h5;
    localparam logic [3:0] space_sup_prog = 4'h6;
    localparam logic [3:0] space_cpu = 4'h7;
    localparam int ack_delay_w = 4;
    localparam int monitor_w = 8;
    localparam logic [7:0] monitor_limit = 8'h40;
    typedef enum logic [1:0] {
        term_ok,
        term_error,
        term_retry,
        term_autovec
    } term_e;
endpackage : bus_master_pkg

// [rtl/term_decode.sv]
// ------------------------------------------------------------
// termination decode: turns acknowledge inputs into one result
// ------------------------------------------------------------
module term_decode
    import bus_master_pkg::*;
(
    // external inputs, active low
    input wire logic ack_upper_n,
    input wire logic ack_lower_n,
    input wire logic bus_fault_n,
    input wire logic halt_n,
    input wire logic auto_vector_request_n,
    // internal sources
    input wire logic int_ack,
    input wire logic int_fault,
    input wire logic int_auto_vector_request,
    input wire logic iack_cycle,
    // result
    output logic done,
    output term_e kind,
    output logic port_8bit
);
    logic ext_ack;
    logic fault;
    logic auto_vector_request;

    assign ext_ack = !ack_upper_n || !ack_lower_n;
    assign fault = !bus_fault_n || int_fault;
    // autovector only counts in interrupt-acknowledge cycles
    assign auto_vector_request = iack_cycle && (!auto_vector_request_n || int_auto_vector_request);
    // lower only is 8-bit; upper or both is 16-bit
    assign port_8bit = ack_upper_n && !ack_lower_n && !int_ack;

    always_comb begin
        done = 1'b0;
        kind = term_ok;
        if (fault && !halt_n) begin
            done = 1'b1;
            kind = term_retry;
        end else if (fault) begin
            done = 1'b1;
            kind = term_error;
        end else if (auto_vector_request) begin
            done = 1'b1;
            kind = term_autovec;
        end else if (ext_ack || int_ack) begin
            done = 1'b1;
            kind = term_ok;
        end
    end
endmodule : term_decode

// [rtl/bus_master.sv]
// ------------------------------------------------------------
// asynchronous bus master signalling
// ------------------------------------------------------------
module bus_master
    import bus_master_pkg::*;
#(
    parameter int aw = addr_w,
    parameter int dw = data_w
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // request from the core
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [aw-1:0] req_addr,
    input wire logic [1:0] req_size,
    input wire logic [3:0] req_space,
    input wire logic req_write,
    input wire logic req_locked,
    input wire logic req_locked_last,
    input wire logic req_iack,
    input wire logic req_external_master,
    input wire logic [dw-1:0] req_wdata,
    // chip-select terms for this access
    input wire logic cs_int_ack,
    input wire logic [ack_delay_w-1:0] ack_delay_bits,
    input wire logic cs_fast,
    input wire logic int_auto_vector_request,
    // completion to the core
    output logic rsp_valid,
    output term_e rsp_kind,
    output logic rsp_port_8bit,
    output logic [dw-1:0] rsp_rdata,
    // bus outputs
    output logic [aw-1:0] addr,
    output logic [1:0] transfer_size,
    output logic [3:0] address_space_code,
    output logic read_write,
    output logic locked_sequence_n,
    output logic address_strobe_n,
    output logic data_strobe_n,
    // data bus pins
    input wire logic [dw-1:0] data_in,
    output logic [dw-1:0] data_out,
    output logic data_oe,
    // termination inputs
    input wire logic ack_upper_n,
    input wire logic ack_lower_n,
    input wire logic bus_fault_n,
    input wire logic halt_n,
    input wire logic auto_vector_request_n
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_wait,
        st_term
    } phase_e;

    typedef struct packed {
        phase_e phase;
        logic [aw-1:0] addr;
        logic [1:0] size;
        logic [3:0] space;
        logic rw;
        logic locked;
        logic last;
        logic iack;
        logic ext_master;
        logic fast;
        logic int_en;
        logic [ack_delay_w-1:0] delay;
        logic [ack_delay_w-1:0] cnt;
        logic [monitor_w-1:0] mon;
        logic as;
        logic ds;
        logic oe;
        logic [dw-1:0] wdata;
        logic rvalid;
        term_e kind;
        logic p8;
        logic [dw-1:0] rdata;
    } state_s;

    state_s r;
    state_s next_r;

    logic done;
    term_e kind;
    logic p8;
    logic int_ack;
    logic int_fault;
    logic [dw-1:0] rd_capture;

    // ------------------------------------------------------------
    // termination
    // ------------------------------------------------------------
    // programmed internal acknowledge fires when the delay expires
    assign int_ack = r.as && r.int_en && (r.cnt >= r.delay);
    // the monitor only watches cycles this device started
    assign int_fault = r.as && !r.ext_master && (r.mon >= monitor_limit);

    term_decode u_term (
        .ack_upper_n(ack_upper_n),
        .ack_lower_n(ack_lower_n),
        .bus_fault_n(bus_fault_n),
        .halt_n(halt_n),
        .auto_vector_request_n(auto_vector_request_n),
        .int_ack(int_ack),
        .int_fault(int_fault),
        .int_auto_vector_request(int_auto_vector_request),
        .iack_cycle(r.iack),
        .done(done),
        .kind(kind),
        .port_8bit(p8)
    );

    // ------------------------------------------------------------
    // falling-edge read capture
    // ------------------------------------------------------------
    // data sampled on the falling edge ending the cycle
    always_ff @(negedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_capture <= '0;
        end else if (clk_en && r.as && r.rw) begin
            rd_capture <= data_in;
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    assign req_ready = (r.phase == st_idle);

    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        case (r.phase)
            st_idle: begin
                next_r.as = 1'b0;
                next_r.ds = 1'b0;
                if (req_valid) begin
                    next_r.phase = st_addr;
                    next_r.addr = req_addr;
                    next_r.size = req_size;
                    next_r.space = req_space;
                    // direction only turns when the request asks for it
                    next_r.rw = !req_write;
                    next_r.locked = req_locked;
                    next_r.last = req_locked_last;
                    next_r.iack = req_iack;
                    next_r.ext_master = req_external_master;
                    next_r.fast = cs_fast;
                    next_r.int_en = cs_int_ack;
                    next_r.delay = ack_delay_bits;
                    next_r.wdata = req_wdata;
                    next_r.cnt = '0;
                    next_r.mon = '0;
                end else if (r.locked && r.last) begin
                    next_r.locked = 1'b0;
                end
            end
            st_addr: begin
                // address strobe, and data strobe on reads only, come one clock in: one fabric edge after start
                next_r.as = 1'b1;
                next_r.ds = r.rw;
                next_r.oe = !r.rw;
                next_r.phase = r.fast ? st_term : st_wait;
            end
            st_wait: begin
                next_r.ds = 1'b1;
                next_r.cnt = r.cnt + 1'b1;
                if (r.mon != '1) begin
                    next_r.mon = r.mon + 1'b1;
                end
                if (done) begin
                    next_r.phase = st_term;
                    next_r.kind = kind;
                    next_r.p8 = p8;
                end
            end
            st_term: begin
                if (r.fast) begin
                    next_r.kind = term_ok;
                    next_r.p8 = 1'b0;
                end
                next_r.as = 1'b0;
                next_r.ds = 1'b0;
                next_r.oe = 1'b0;
                next_r.rvalid = 1'b1;
                next_r.rdata = rd_capture;
                if (r.last) begin
                    next_r.locked = 1'b0;
                end
                next_r.phase = st_idle;
            end
            default: begin
                next_r.phase = st_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.rw <= 1'b1;
            r.phase <= st_idle;
            r.kind <= term_ok;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign addr = r.addr;
    assign transfer_size = r.size;
    assign address_space_code = r.space;
    assign read_write = r.rw;
    assign locked_sequence_n = !r.locked;
    assign address_strobe_n = !r.as;
    assign data_strobe_n = !r.ds;
    assign data_out = r.wdata;
    assign data_oe = r.oe;
    assign rsp_valid = r.rvalid;
    assign rsp_kind = r.kind;
    assign rsp_port_8bit = r.p8;
    assign rsp_rdata = r.rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence start_s;
        req_ready && req_valid;
    endsequence

    sequence strobe_s;
        ##1 !address_strobe_n;
    endsequence

    sequence taken_s;
        (start_s and clk_en) ##1 clk_en;
    endsequence

    strobe_after_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        taken_s |-> strobe_s)
        else $error("address strobe not asserted after start");

    addr_taken_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        taken_s |=> addr == $past(req_addr, 2))
        else $error("address not the requested one");

    size_taken_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        taken_s |=> transfer_size == $past(req_size, 2))
        else $error("size not the requested one");

    space_taken_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        taken_s |=> address_space_code == $past(req_space, 2))
        else $error("space code not the requested one");

    dir_taken_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        taken_s |=> read_write == !$past(req_write, 2))
        else $error("direction not the requested one");

    read_ds_with_as_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(address_strobe_n) && read_write |-> !data_strobe_n)
        else $error("read data strobe late");

    write_ds_late_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(address_strobe_n) && !read_write |-> data_strobe_n)
        else $error("write data strobe early");

    size_stable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !address_strobe_n && !$past(address_strobe_n) |-> $stable(transfer_size))
        else $error("size changed under strobe");

    addr_stable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !address_strobe_n && !$past(address_strobe_n) |-> $stable(addr))
        else $error("address changed under strobe");

    space_stable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !address_strobe_n && !$past(address_strobe_n) |-> $stable(address_space_code))
        else $error("space code changed under strobe");

    rw_stable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !address_strobe_n && !$past(address_strobe_n) |-> $stable(read_write))
        else $error("direction changed under strobe");

    write_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !data_strobe_n && !read_write |-> data_oe)
        else $error("write data not driven");

    fast_two_clk_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_addr && r.fast && clk_en ##1 clk_en |-> ##1 rsp_valid)
        else $error("fast cycle not two clocks");

    idle_strobes_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rsp_valid |-> address_strobe_n && data_strobe_n)
        else $error("strobes held after termination");

    auto_vector_request_ignored_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        rsp_valid && !r.iack |-> rsp_kind != term_autovec)
        else $error("autovector outside interrupt acknowledge");

    lock_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_term && r.locked && !r.last && clk_en |=> !locked_sequence_n)
        else $error("locked output dropped before last cycle");

    lock_release_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_term && r.last && clk_en |=> locked_sequence_n)
        else $error("locked output held after last cycle");

    fault_error_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_wait && !bus_fault_n && halt_n && clk_en |=> rsp_kind == term_error)
        else $error("bus fault not reported as error");

    fault_retry_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_wait && !bus_fault_n && !halt_n && clk_en |=> rsp_kind == term_retry)
        else $error("fault with halt not reported as retry");

    monitor_fault_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_wait && !r.ext_master && r.mon >= monitor_limit && clk_en |=>
        rsp_kind inside {term_error, term_retry})
        else $error("bus monitor did not end the cycle");

    port_narrow_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_wait && ack_upper_n && !ack_lower_n && !int_ack && clk_en |=>
        rsp_port_8bit)
        else $error("lower acknowledge not reported as 8-bit");

    port_wide_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_wait && !ack_upper_n && clk_en |=> !rsp_port_8bit)
        else $error("upper acknowledge not reported as 16-bit");

    early_ack_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_wait && r.int_en && !int_ack && !ack_upper_n && clk_en |=>
        r.phase == st_term)
        else $error("early external acknowledge ignored");

    auto_vector_request_ends_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_wait && r.iack && !auto_vector_request_n && bus_fault_n && !int_fault
        && clk_en |=> rsp_kind == term_autovec)
        else $error("autovector did not end interrupt acknowledge");

    idle_bus_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        r.phase == st_idle |-> address_strobe_n && data_strobe_n)
        else $error("strobes asserted while idle");

    write_ds_next_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(address_strobe_n) && !read_write && !r.fast && clk_en |=> !data_strobe_n)
        else $error("write data strobe not one clock after address strobe");
endmodule : bus_master

// [verification/slave_model.sv]
// ------------------------------------------------------------
// slave model: answers after a set number of waits in modes 0 to 4; other modes never answer
// ------------------------------------------------------------
module slave_model (
    // bus side
    input wire logic sys_clk,
    input wire logic address_strobe_n,
    input wire logic data_strobe_n,
    input wire logic read_write,
    // control from the bench
    input wire logic [2:0] mode,
    input wire logic [3:0] wait_n,
    input wire logic [15:0] rd_pat,
    // answers
    output logic [15:0] data_in,
    output logic ack_upper_n,
    output logic ack_lower_n,
    output logic bus_fault_n,
    output logic halt_n,
    output logic auto_vector_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic go;
    initial begin
        data_in = 16'h0000;
        ack_upper_n = 1'b1;
        ack_lower_n = 1'b1;
        bus_fault_n = 1'b1;
        halt_n = 1'b1;
        auto_vector_request_n = 1'b1;
    end
    // answers change only off the sampling edge; released when strobe goes
    always @(negedge sys_clk) begin
        cnt = address_strobe_n ? 0 : cnt + 1;
        go = cnt > wait_n;
        ack_upper_n <= !(go && mode == 3'h0);
        ack_lower_n <= !(go && mode == 3'h1);
        bus_fault_n <= !(go && (mode == 3'h2 || mode == 3'h3));
        halt_n <= !(go && mode == 3'h3);
        auto_vector_request_n <= !(go && mode == 3'h4);
        // released data lines toggle so a stale value never matches
        data_in <= (!data_strobe_n && read_write) ? rd_pat : ~data_in;
    end
endmodule : slave_model

// [verification/tb_async_bus_master_signalling.sv]
module tb_async_bus_master_signalling
    import bus_master_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, arst_n = 0, req_valid = 0, req_write = 0, req_locked = 0;
    logic req_locked_last = 0, req_iack = 0, req_ext = 0, cs_int_ack = 0, cs_fast = 0;
    logic int_auto_vector_request = 0, req_ready, rsp_valid, rsp_port_8bit, read_write, data_oe;
    logic locked_sequence_n, address_strobe_n, data_strobe_n;
    logic ack_upper_n, ack_lower_n, bus_fault_n, halt_n, auto_vector_request_n;
    logic [31:0] req_addr = 0, addr;
    logic [1:0] req_size = 0, transfer_size;
    logic [3:0] req_space = 0, address_space_code, ack_delay_bits = 0, wait_n = 0;
    logic [15:0] req_wdata = 0, rsp_rdata, data_in, data_out, rd_pat = 0;
    logic [2:0] mode = 0;
    logic clk_en = 1'b1;
    term_e rsp_kind;
    int n_fail = 0, cmp_count = 0, lat, as_at, ds_at;
    always #4 sys_clk = ~sys_clk;
    bus_master dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_size(req_size), .req_space(req_space), .req_write(req_write),
        .req_locked(req_locked), .req_locked_last(req_locked_last), .req_iack(req_iack),
        .req_external_master(req_ext), .req_wdata(req_wdata), .cs_int_ack(cs_int_ack),
        .ack_delay_bits(ack_delay_bits), .cs_fast(cs_fast), .int_auto_vector_request(int_auto_vector_request),
        .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_port_8bit(rsp_port_8bit),
        .rsp_rdata(rsp_rdata), .addr(addr), .transfer_size(transfer_size),
        .address_space_code(address_space_code), .read_write(read_write),
        .locked_sequence_n(locked_sequence_n), .address_strobe_n(address_strobe_n),
        .data_strobe_n(data_strobe_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .ack_upper_n(ack_upper_n), .ack_lower_n(ack_lower_n),
        .bus_fault_n(bus_fault_n), .halt_n(halt_n),
        .auto_vector_request_n(auto_vector_request_n));
    slave_model slave (.sys_clk(sys_clk), .address_strobe_n(address_strobe_n),
        .data_strobe_n(data_strobe_n), .read_write(read_write), .mode(mode),
        .wait_n(wait_n), .rd_pat(rd_pat), .data_in(data_in), .ack_upper_n(ack_upper_n),
        .ack_lower_n(ack_lower_n), .bus_fault_n(bus_fault_n), .halt_n(halt_n),
        .auto_vector_request_n(auto_vector_request_n));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one bus cycle; lat counts edges from the take to the response
    task run(input logic [31:0] a, input logic [1:0] sz, input logic [3:0] sp,
             input logic wr, input logic [15:0] wd);
        @(negedge sys_clk);
        req_addr = a;
        req_size = sz;
        req_space = sp;
        req_write = wr;
        req_wdata = wd;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        lat = 0;
        as_at = 0;
        ds_at = 0;
        while (rsp_valid !== 1'b1 && lat < 200) begin
            if (address_strobe_n === 1'b0) begin
                if (as_at == 0) as_at = lat;
                chk("addr", addr, a);
                chk("size", transfer_size, sz);
                chk("space", address_space_code, sp);
                chk("dir", read_write, !wr);
                chk("ready", req_ready, 1'b0);
            end
            if (data_strobe_n === 1'b0 && ds_at == 0) begin
                ds_at = lat;
                if (wr) chk("wdata", data_out, wd);
                if (wr) chk("oe", data_oe, 1'b1);
            end
            @(negedge sys_clk);
            lat++;
        end
        chk("rsp", rsp_valid, 1'b1);
        chk("as_at", as_at, 1);
        chk("as_idle", address_strobe_n, 1'b1);
        chk("ds_idle", data_strobe_n, 1'b1);
    endtask : run
    task t_rw;
        mode = 3'h0;
        wait_n = 4'h2;
        rd_pat = 16'h1234;
        run(32'h0000_1001, size_byte, space_user_data, 1'b0, 16'h0000);
        chk("lat", lat, 5);
        chk("ds_rd", ds_at, as_at);
        chk("rdata", rsp_rdata, 16'h1234);
        chk("p8", rsp_port_8bit, 1'b0);
        mode = 3'h1;
        wait_n = 4'h0;
        run(32'h0000_2000, size_word, space_sup_data, 1'b1, 16'ha5c3);
        chk("ds_wr", ds_at, as_at + 1);
        chk("p8", rsp_port_8bit, 1'b1);
        chk("kind", rsp_kind, term_ok);
        chk("dir_hold", read_write, 1'b0);
        run(32'h0000_2002, size_three, space_user_prog, 1'b1, 16'h5a3c);
        chk("lat", lat, 3);
        $display("test read and write done");
    endtask : t_rw
    task t_fault;
        mode = 3'h2;
        run(32'h0000_3000, size_long, space_sup_prog, 1'b0, 16'h0000);
        chk("kind", rsp_kind, term_error);
        mode = 3'h3;
        run(32'h0000_3004, size_long, space_sup_prog, 1'b0, 16'h0000);
        chk("kind", rsp_kind, term_retry);
        mode = 3'h6;
        run(32'h0000_3008, size_word, space_user_data, 1'b0, 16'h0000);
        chk("kind", rsp_kind, term_error);
        chk("mon", lat < 80, 1'b1);
        // cycles of another master are not timed out: only the late external fault ends it
        req_ext = 1'b1;
        fork
            run(32'h0000_300a, size_word, space_user_data, 1'b0, 16'h0000);
            begin
                repeat (90) @(negedge sys_clk);
                mode = 3'h2;
            end
        join
        chk("ext_mon", lat > 80, 1'b1);
        chk("kind", rsp_kind, term_error);
        req_ext = 1'b0;
        $display("test faults done");
    endtask : t_fault
    task t_auto_vector_request;
        req_iack = 1'b1;
        mode = 3'h4;
        run(32'hffff_fff3, size_byte, space_cpu, 1'b0, 16'h0000);
        chk("kind", rsp_kind, term_autovec);
        mode = 3'h6;
        int_auto_vector_request = 1'b1;
        run(32'hffff_fff5, size_byte, space_cpu, 1'b0, 16'h0000);
        chk("kind", rsp_kind, term_autovec);
        req_iack = 1'b0;
        mode = 3'h4;
        cs_int_ack = 1'b1;
        ack_delay_bits = 4'h3;
        run(32'h0000_4000, size_word, space_user_data, 1'b0, 16'h0000);
        chk("kind", rsp_kind, term_ok);
        chk("int_ack", lat, 6);
        int_auto_vector_request = 1'b0;
        ack_delay_bits = 4'hf;
        mode = 3'h0;
        wait_n = 4'h1;
        run(32'h0000_4002, size_word, space_user_data, 1'b0, 16'h0000);
        chk("early", lat, 4);
        cs_int_ack = 1'b0;
        $display("test autovector and internal ack done");
    endtask : t_auto_vector_request
    task t_fast;
        cs_fast = 1'b1;
        mode = 3'h6;
        run(32'h0000_5000, size_word, space_sup_data, 1'b0, 16'h0000);
        chk("fast", lat, 2);
        chk("kind", rsp_kind, term_ok);
        cs_fast = 1'b0;
        $display("test fast done");
    endtask : t_fast
    task t_lock;
        mode = 3'h0;
        wait_n = 4'h0;
        req_locked = 1'b1;
        run(32'h0000_6000, size_byte, space_sup_data, 1'b0, 16'h0000);
        chk("lock", locked_sequence_n, 1'b0);
        req_locked_last = 1'b1;
        run(32'h0000_6000, size_byte, space_sup_data, 1'b1, 16'h00ff);
        req_locked = 1'b0;
        req_locked_last = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("unlock", locked_sequence_n, 1'b1);
        $display("test locked done");
    endtask : t_lock
    // a request while the enable is low must not start a cycle
    task t_freeze;
        @(negedge sys_clk);
        clk_en = 1'b0;
        req_addr = 32'h0000_7000;
        req_valid = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("frz_as", address_strobe_n, 1'b1);
        chk("frz_addr", addr, 32'h0000_6000);
        chk("frz_ready", req_ready, 1'b1);
        req_valid = 1'b0;
        clk_en = 1'b1;
        $display("test freeze done");
    endtask : t_freeze
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        arst_n = 1'b1;
        t_rw;
        t_fault;
        t_auto_vector_request;
        t_fast;
        t_lock;
        t_freeze;
        finish_test;
    end
endmodule : tb_async_bus_master_signalling
